// ---- hw/smc_core.sv ----
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ns
// Overview of operation
// (R1) quadrature decoded into 24-bit position count
// (R2) address and data share one 8-bit bus
// (R3) exactly one of four control modes runs
// (R4) profile generator drives trapezoid and integral velocity
// (R5) programmable filter computes command each sample
// (R6) command out as byte and pwm
// (R7) phases sequenced by position, overlap, advance
// (R8) profile and init flags on pins
// (R9) limit or stop interrupts normal control
// (R10) host access anytime, command only on ticks; the code also zeroes the command in any cycle on limit, stop or init
// (R11) sync pin aligns several controllers
// (R12) position wraps modulo 2^24 both directions
module smc_core import smc_pkg::*; (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       ale,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    input  wire logic [7:0] ad_in,
    output logic      [7:0] ad_out,
    output logic            ad_oe_n,
    input  wire logic       enc_a,
    input  wire logic       enc_b,
    input  wire logic       limit_n,
    input  wire logic       stop_n,
    input  wire logic       sync_in,
    output logic            sync_out,
    output logic            sync_oe_n,
    output logic      [7:0] mcmd,
    output logic            pwm_out,
    output logic            pwm_sign,
    output logic      [2:0] phase,
    output logic            prof_flag,
    output logic            init_flag,
    output logic            irq
);
    smc_mode_t                mode_r;
    logic                     comm_en_r, sync_m_r;
    logic [7:0]               addr_r, timer_r, gain_r, zero_r, acc_r, vmax_r;
    logic [7:0]               seg_r, ovl_r, adv_r, cvel_r;
    logic [23:0]              tgt_r, des_r, pos_prev_r, pos;
    logic signed [11:0]       vel_r, e_prev_r;
    logic [SMC_NIRQ-1:0]      ists_r, ien_r, ev;
    logic [11:0]              cnt_r;
    logic                     tick;
    logic [2:0]               sync_s_r, lim_s_r, stp_s_r;
    logic                     step_up, step_dn, emerg;
    logic [2:0]               preset_we;
    logic [9:0]               cpos_r, ring, pidx;
    logic [10:0]              padd;
    logic [2:0]               ph_nxt;

    // ==========================================
    // helpers
    function automatic smc_mode_t mode_dec(input logic [1:0] c);
        case (c)
            2'd0:    mode_dec = SMC_HOLD;
            2'd1:    mode_dec = SMC_PVEL;
            2'd2:    mode_dec = SMC_TRAP;
            default: mode_dec = SMC_IVEL;
        endcase
    endfunction

    function automatic logic [1:0] mode_enc(input smc_mode_t m);
        case (m)
            SMC_PVEL: mode_enc = 2'd1;
            SMC_TRAP: mode_enc = 2'd2;
            SMC_IVEL: mode_enc = 2'd3;
            default:  mode_enc = 2'd0;
        endcase
    endfunction

    function automatic logic signed [11:0] sat12(input logic signed [23:0] v);
        if (v > 24'sd2047)        sat12 = 12'sd2047;
        else if (v < -24'sd2048)  sat12 = -12'sd2048;
        else                      sat12 = v[11:0];
    endfunction

    function automatic logic signed [11:0] step_toward(input logic signed [11:0] v,
                                                       input logic signed [11:0] g,
                                                       input logic [7:0] a);
        logic signed [12:0] d;
        d = 13'(g) - 13'(v);
        if (d > $signed({5'h00, a}))        step_toward = 12'(13'(v) + $signed({5'h00, a}));
        else if (d < -$signed({5'h00, a}))  step_toward = 12'(13'(v) - $signed({5'h00, a}));
        else                                step_toward = g;
    endfunction

    function automatic logic in_win(input logic [9:0] p, input logic [9:0] st,
                                    input logic [9:0] r, input logic [9:0] len);
        logic [10:0] q;
        q = (p >= st) ? {1'b0, p - st} : 11'({1'b0, p} + {1'b0, r} - {1'b0, st});
        in_win = q < {1'b0, len};
    endfunction

    // ==========================================
    // encoder and pwm
    smc_quad u_quad (
        .mclk        (mclk),
        .rst         (rst),
        .enc_a       (enc_a),
        .enc_b       (enc_b),
        .preset_we   (preset_we),
        .preset_byte (ad_in),
        .pos         (pos),
        .step_up     (step_up),
        .step_dn     (step_dn)
    );

    smc_pwm u_pwm (
        .mclk     (mclk),
        .rst      (rst),
        .cmd      (mcmd),
        .pwm_out  (pwm_out),
        .pwm_sign (pwm_sign)
    );

    // ==========================================
    // pin synchronisers; stage 2 feeds logic, stage 3 is the edge history
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_s_r <= 3'h7;
            lim_s_r  <= 3'h7;
            stp_s_r  <= 3'h7;
        end else begin
            sync_s_r <= {sync_s_r[1:0], sync_in};
            lim_s_r  <= {lim_s_r[1:0], limit_n};
            stp_s_r  <= {stp_s_r[1:0], stop_n};
        end
    end

    // (R9) either emergency input halts control
    assign emerg = ~lim_s_r[1] | ~stp_s_r[1];

    // ==========================================
    // host bus
    // (R2) address phase latches the shared bus
    always_ff @(posedge mclk) begin
        if (rst) addr_r <= 8'h00;
        else if (ale) addr_r <= ad_in;
    end

    assign preset_we = {3{wr_stb}} & {addr_r == SMC_A_POS2, addr_r == SMC_A_POS1,
                                      addr_r == SMC_A_POS0};

    // (R10) writes land any cycle, loop samples them on ticks
    always_ff @(posedge mclk) begin
        if (rst) begin
            timer_r <= SMC_RST_TIMER;
            gain_r  <= SMC_RST_GAIN;
            zero_r  <= SMC_RST_ZERO;
            acc_r   <= SMC_RST_ACC;
            vmax_r  <= SMC_RST_VMAX;
            seg_r   <= SMC_RST_SEG;
            ovl_r   <= 8'h00;
            adv_r   <= 8'h00;
            cvel_r  <= 8'h00;
            tgt_r   <= 24'h000000;
            ien_r   <= '0;
        end else if (wr_stb) begin
            case (addr_r)
                SMC_A_TIMER: timer_r <= ad_in;
                SMC_A_GAIN:  gain_r <= ad_in;
                SMC_A_ZERO:  zero_r <= ad_in;
                SMC_A_ACC:   acc_r <= ad_in;
                SMC_A_VMAX:  vmax_r <= ad_in;
                SMC_A_SEG:   seg_r <= ad_in;
                SMC_A_OVL:   ovl_r <= ad_in;
                SMC_A_ADV:   adv_r <= ad_in;
                SMC_A_CVEL:  cvel_r <= ad_in;
                SMC_A_TGT0:  tgt_r[7:0] <= ad_in;
                SMC_A_TGT1:  tgt_r[15:8] <= ad_in;
                SMC_A_TGT2:  tgt_r[23:16] <= ad_in;
                SMC_A_IEN:   ien_r <= ad_in[SMC_NIRQ-1:0];
                default: ;
            endcase
        end
    end

    // (R3) mode write selects one mode, leaves init
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_r    <= SMC_HOLD;
            comm_en_r <= 1'b0;
            sync_m_r  <= 1'b0;
            init_flag <= 1'b1;
        end else if (wr_stb && addr_r == SMC_A_MODE) begin
            mode_r    <= mode_dec(ad_in[SMC_F_MODE_LO +: 2]);
            comm_en_r <= ad_in[SMC_F_COMM];
            sync_m_r  <= ad_in[SMC_F_SYNCM];
            init_flag <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ad_out  <= 8'h00;
            ad_oe_n <= 1'b1;
        end else begin
            ad_oe_n <= ~rd_stb;
            if (rd_stb) begin
                case (addr_r)
                    SMC_A_MODE:  ad_out <= {4'h0, sync_m_r, comm_en_r, mode_enc(mode_r)};
                    SMC_A_FLAGS: ad_out <= {4'h0, ~stp_s_r[1], ~lim_s_r[1], init_flag,
                                            prof_flag};
                    SMC_A_ISTS:  ad_out <= 8'({ists_r});
                    SMC_A_IEN:   ad_out <= 8'({ien_r});
                    SMC_A_TIMER: ad_out <= timer_r;
                    SMC_A_GAIN:  ad_out <= gain_r;
                    SMC_A_ZERO:  ad_out <= zero_r;
                    SMC_A_TGT0:  ad_out <= tgt_r[7:0];
                    SMC_A_TGT1:  ad_out <= tgt_r[15:8];
                    SMC_A_TGT2:  ad_out <= tgt_r[23:16];
                    SMC_A_POS0:  ad_out <= pos[7:0];
                    SMC_A_POS1:  ad_out <= pos[15:8];
                    SMC_A_POS2:  ad_out <= pos[23:16];
                    SMC_A_CVEL:  ad_out <= cvel_r;
                    SMC_A_ACC:   ad_out <= acc_r;
                    SMC_A_VMAX:  ad_out <= vmax_r;
                    SMC_A_SEG:   ad_out <= seg_r;
                    SMC_A_OVL:   ad_out <= ovl_r;
                    SMC_A_ADV:   ad_out <= adv_r;
                    SMC_A_MCMD:  ad_out <= mcmd;
                    default:     ad_out <= 8'h00;
                endcase
            end
        end
    end

    // ==========================================
    // sample timer
    // (R10) programmable sample period
    // (R11) follower restarts its period on the leader's low pulse
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_r <= 12'h000;
        end else if ((cnt_r == 12'h000) || (!sync_m_r && sync_s_r[2] && !sync_s_r[1])) begin
            cnt_r <= {timer_r, {SMC_PRESCALE_LOG2{1'b1}}};
        end else begin
            cnt_r <= cnt_r - 12'h001;
        end
    end

    assign tick = (cnt_r == 12'h000);

    // (R11) leader pulls the open-drain sync line low one cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_out  <= 1'b0;
            sync_oe_n <= 1'b1;
        end else begin
            sync_out  <= 1'b0;
            sync_oe_n <= ~(sync_m_r & tick);
        end
    end

    // ==========================================
    // profile generator and filter
    logic signed [23:0] rem, perr;
    logic signed [11:0] e_cur, v_nxt, vmax_s, vgoal;
    logic [23:0]        absrem, brake;
    logic [11:0]        absv;
    logic [33:0]        need;
    logic signed [21:0] u_raw;
    logic signed [17:0] u_sh;
    logic               done;

    always_comb begin
        rem    = $signed(tgt_r - des_r);
        absrem = rem[23] ? 24'(-rem) : rem;
        absv   = vel_r[11] ? 12'(-vel_r) : vel_r;
        brake  = {12'h000, absv} * {12'h000, absv};
        need   = 34'({absrem, 1'b0}) * 34'({acc_r});
        vmax_s = $signed({4'h0, vmax_r});
        vgoal  = (need <= 34'({brake})) ? 12'sd0 : (rem[23] ? 12'(-vmax_s) : vmax_s);
        done   = 1'b0;
        v_nxt  = vel_r;
        case (mode_r)
            // (R4) trapezoid: ramp, cruise, brake to target
            SMC_TRAP: begin
                v_nxt = step_toward(vel_r, vgoal, acc_r);
                if (rem == 24'sd0 || {12'h000, (v_nxt[11] ? 12'(-v_nxt) : v_nxt)} >= absrem ||
                    (v_nxt == 12'sd0 && vgoal == 12'sd0)) begin
                    done  = 1'b1;
                    v_nxt = 12'sd0;
                end
            end
            // (R4) integral velocity: linear ramp to command
            SMC_IVEL: v_nxt = step_toward(vel_r, 12'($signed(cvel_r)), acc_r);
            default:  v_nxt = 12'sd0;
        endcase
        // (R5) error per mode
        if (mode_r == SMC_PVEL) begin
            perr = 24'($signed(cvel_r)) - $signed(pos - pos_prev_r);
        end else begin
            perr = $signed(des_r - pos);
        end
        e_cur = sat12(perr);
        u_raw = e_cur * $signed({1'b0, gain_r}) - e_prev_r * $signed({1'b0, zero_r});
        u_sh  = 18'(u_raw >>> SMC_PRESCALE_LOG2);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            des_r      <= 24'h000000;
            vel_r      <= 12'sd0;
            e_prev_r   <= 12'sd0;
            pos_prev_r <= 24'h000000;
            mcmd       <= 8'h00;
            prof_flag  <= 1'b0;
        end else begin
            if (wr_stb && addr_r == SMC_A_MODE) begin
                prof_flag <= (mode_dec(ad_in[SMC_F_MODE_LO +: 2]) == SMC_TRAP);
            end
            // (R9) emergency aborts profile and zeroes command
            if (emerg || init_flag) begin
                des_r     <= pos;
                vel_r     <= 12'sd0;
                e_prev_r  <= 12'sd0;
                mcmd      <= 8'h00;
                if (emerg) prof_flag <= 1'b0;
            end else if (tick) begin
                // (R10) command updated at sample instants; the emergency and init branch above zeroes it in any cycle
                pos_prev_r <= pos;
                vel_r      <= v_nxt;
                e_prev_r   <= e_cur;
                case (mode_r)
                    SMC_HOLD: des_r <= tgt_r;
                    SMC_TRAP: des_r <= done ? tgt_r : des_r + 24'(v_nxt);
                    SMC_IVEL: des_r <= des_r + 24'(v_nxt);
                    default:  des_r <= pos;
                endcase
                if (done) prof_flag <= 1'b0;
                // (R6) saturated byte command
                if (u_sh > 18'sd127)       mcmd <= 8'h7f;
                else if (u_sh < -18'sd128) mcmd <= 8'h80;
                else                       mcmd <= u_sh[7:0];
            end
        end
    end

    // ==========================================
    // commutator
    assign ring = 10'({seg_r, 1'b0}) + 10'({seg_r});
    assign padd = {1'b0, cpos_r} + 11'({adv_r});
    assign pidx = (padd >= {1'b0, ring}) ? 10'(padd - {1'b0, ring}) : padd[9:0];

    always_ff @(posedge mclk) begin
        if (rst) begin
            cpos_r <= 10'h000;
        end else if (cpos_r >= ring) begin
            cpos_r <= 10'h000;
        end else if (step_up) begin
            cpos_r <= (cpos_r == ring - 10'h001) ? 10'h000 : cpos_r + 10'h001;
        end else if (step_dn) begin
            cpos_r <= (cpos_r == 10'h000) ? ring - 10'h001 : cpos_r - 10'h001;
        end
    end

    // (R7) phase windows with overlap and advance
    always_comb begin
        ph_nxt = 3'h0;
        for (int k = 0; k < 3; k++) begin
            ph_nxt[k] = in_win(pidx, 10'(k * seg_r), ring, 10'({seg_r}) + 10'({ovl_r}));
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) phase <= 3'h0;
        else     phase <= (comm_en_r && !emerg && ring != 10'h000) ? ph_nxt : 3'h0;
    end

    // ==========================================
    // interrupts: hardware set beats software clear
    assign ev[SMC_I_DONE]  = prof_flag & tick & done & ~emerg & ~init_flag;
    assign ev[SMC_I_LIMIT] = lim_s_r[2] & ~lim_s_r[1];
    assign ev[SMC_I_STOP]  = stp_s_r[2] & ~stp_s_r[1];

    always_ff @(posedge mclk) begin
        if (rst) begin
            ists_r <= '0;
            irq    <= 1'b0;
        end else begin
            ists_r <= (ists_r & ~((wr_stb && addr_r == SMC_A_ICLR) ?
                                  ad_in[SMC_NIRQ-1:0] : {SMC_NIRQ{1'b0}})) | ev;
            // (R8) status flags kept and exported
            irq    <= |(ists_r & ien_r);
        end
    end
endmodule

// ---- hw/smc_pkg.sv ----
package smc_pkg;

    // ==========================================
    // register offsets on the multiplexed bus
    localparam logic [7:0] SMC_A_MODE  = 8'h00;
    localparam logic [7:0] SMC_A_FLAGS = 8'h01;
    localparam logic [7:0] SMC_A_ISTS  = 8'h02;
    localparam logic [7:0] SMC_A_ICLR  = 8'h03;
    localparam logic [7:0] SMC_A_IEN   = 8'h04;
    localparam logic [7:0] SMC_A_TIMER = 8'h05;
    localparam logic [7:0] SMC_A_GAIN  = 8'h06;
    localparam logic [7:0] SMC_A_ZERO  = 8'h07;
    localparam logic [7:0] SMC_A_TGT0  = 8'h08;
    localparam logic [7:0] SMC_A_TGT1  = 8'h09;
    localparam logic [7:0] SMC_A_TGT2  = 8'h0a;
    localparam logic [7:0] SMC_A_POS0  = 8'h0b;
    localparam logic [7:0] SMC_A_POS1  = 8'h0c;
    localparam logic [7:0] SMC_A_POS2  = 8'h0d;
    localparam logic [7:0] SMC_A_CVEL  = 8'h0e;
    localparam logic [7:0] SMC_A_ACC   = 8'h0f;
    localparam logic [7:0] SMC_A_VMAX  = 8'h10;
    localparam logic [7:0] SMC_A_SEG   = 8'h11;
    localparam logic [7:0] SMC_A_OVL   = 8'h12;
    localparam logic [7:0] SMC_A_ADV   = 8'h13;
    localparam logic [7:0] SMC_A_MCMD  = 8'h14;

    // ==========================================
    // mode register fields
    localparam int SMC_F_MODE_LO = 0;
    localparam int SMC_F_COMM    = 2;
    localparam int SMC_F_SYNCM   = 3;

    // ==========================================
    // interrupt status bits
    localparam int SMC_I_DONE  = 0;
    localparam int SMC_I_LIMIT = 1;
    localparam int SMC_I_STOP  = 2;
    localparam int SMC_NIRQ    = 3;

    // ==========================================
    // reset values
    localparam logic [7:0] SMC_RST_TIMER = 8'h3f;
    localparam logic [7:0] SMC_RST_GAIN  = 8'h10;
    localparam logic [7:0] SMC_RST_ZERO  = 8'h00;
    localparam logic [7:0] SMC_RST_ACC   = 8'h01;
    localparam logic [7:0] SMC_RST_VMAX  = 8'h20;
    localparam logic [7:0] SMC_RST_SEG   = 8'h10;

    // sample period is (timer+1) units of 2^this clocks (16)
    localparam int SMC_PRESCALE_LOG2 = 4;

    // ==========================================
    typedef enum logic [3:0] {
        SMC_HOLD = 4'b0001,
        SMC_PVEL = 4'b0010,
        SMC_TRAP = 4'b0100,
        SMC_IVEL = 4'b1000
    } smc_mode_t;

endpackage

// ---- hw/smc_quad.sv ----
`timescale 1ns/1ns
module smc_quad import smc_pkg::*; (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    input  wire logic [2:0]  preset_we,
    input  wire logic [7:0]  preset_byte,
    output logic      [23:0] pos,
    output logic             step_up,
    output logic             step_dn
);
    logic [1:0] a_s_r;
    logic [1:0] b_s_r;
    logic       a_p_r;
    logic       b_p_r;
    logic       chg;
    logic       up;

    // ==========================================
    // two-stage synchronisers, encoder is asynchronous
    always_ff @(posedge mclk) begin
        if (rst) begin
            a_s_r <= 2'h0;
            b_s_r <= 2'h0;
            a_p_r <= 1'b0;
            b_p_r <= 1'b0;
        end else begin
            a_s_r <= {a_s_r[0], enc_a};
            b_s_r <= {b_s_r[0], enc_b};
            a_p_r <= a_s_r[1];
            b_p_r <= b_s_r[1];
        end
    end

    // (R1) quadrature count decode
    // a double transition is an illegal jump and is dropped
    assign chg = (a_s_r[1] ^ a_p_r) ^ (b_s_r[1] ^ b_p_r);
    assign up  = a_p_r ^ b_s_r[1];

    always_ff @(posedge mclk) begin
        if (rst) begin
            step_up <= 1'b0;
            step_dn <= 1'b0;
        end else begin
            step_up <= chg & up;
            step_dn <= chg & ~up;
        end
    end

    // (R12) modulo wrap both ways
    // a preset byte write wins over a count in the same cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            pos <= 24'h000000;
        end else if (|preset_we) begin
            if (preset_we[0]) pos[7:0]   <= preset_byte;
            if (preset_we[1]) pos[15:8]  <= preset_byte;
            if (preset_we[2]) pos[23:16] <= preset_byte;
        end else if (step_up) begin
            pos <= pos + 24'h000001;
        end else if (step_dn) begin
            pos <= pos - 24'h000001;
        end
    end
endmodule

// ---- hw/smc_pwm.sv ----
`timescale 1ns/1ns
module smc_pwm import smc_pkg::*; (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [7:0] cmd,
    output logic            pwm_out,
    output logic            pwm_sign
);
    logic [6:0] cnt_r;
    logic [6:0] mag_r;
    logic [7:0] abs_cmd;

    assign abs_cmd = cmd[7] ? (8'h00 - cmd) : cmd;

    // (R6) pwm form of the command
    // duty and sign reload only at period wrap so no runt pulses
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_r    <= 7'h00;
            mag_r    <= 7'h00;
            pwm_out  <= 1'b0;
            pwm_sign <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 7'h01;
            if (cnt_r == 7'h7f) begin
                mag_r    <= abs_cmd[7] ? 7'h7f : abs_cmd[6:0];
                pwm_sign <= cmd[7];
            end
            pwm_out <= (cnt_r < mag_r);
        end
    end
endmodule

// ---- verification/smc_enc_model.sv ----
`timescale 1ns/1ns
// ==========================================
// quadrature source; each state holds 8 clocks, past the synchroniser delay
module smc_enc_model (
    input  wire logic mclk,
    output logic      enc_a,
    output logic      enc_b
);
    logic [1:0] s_r = 2'h0;
    assign {enc_a, enc_b} = {s_r[1], s_r[1] ^ s_r[0]};
    task automatic step(input logic up);
        @(posedge mclk);
        s_r <= up ? s_r + 2'h1 : s_r - 2'h1;
        repeat (8) @(posedge mclk);
    endtask
endmodule

// ---- verification/smc_chk.sv ----
`timescale 1ns/1ns
// ==========================================
module smc_chk (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       rd_stb,
    input wire logic [7:0] ad_out,
    input wire logic       ad_oe_n,
    input wire logic       limit_n,
    input wire logic       stop_n,
    input wire logic       sync_out,
    input wire logic       sync_oe_n,
    input wire logic [7:0] mcmd,
    input wire logic       pwm_out,
    input wire logic [2:0] phase,
    input wire logic       prof_flag,
    input wire logic       init_flag,
    input wire logic       irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // idle command must drain the pwm period that was loaded before it
    logic [7:0] zc_r;
    always_ff @(posedge mclk) begin
        if (rst || mcmd != 8'h00) zc_r <= 8'h00;
        else if (zc_r != 8'hff) zc_r <= zc_r + 8'h01;
    end
    a_oe_after_rd: assert property (rd_stb |=> !ad_oe_n)
        else $error("bus not driven after read");
    a_oe_idle_high: assert property (!rd_stb |=> ad_oe_n)
        else $error("bus driven without read");
    a_out_hold: assert property (!rd_stb |=> $stable(ad_out))
        else $error("read data moved without read");
    a_emerg_quiet: assert property ((!stop_n || !limit_n) [*8] |-> mcmd == 8'h00 && phase == 3'h0)
        else $error("motor active in emergency");
    a_init_no_rise: assert property (!$rose(init_flag))
        else $error("init flag rose outside reset");
    a_init_no_cmd: assert property (init_flag |-> mcmd == 8'h00 && !prof_flag)
        else $error("command while initialising");
    a_pwm_idle_low: assert property (zc_r >= 8'd140 |-> !pwm_out)
        else $error("pwm high with zero command");
    a_sync_drv_low: assert property (sync_out == 1'b0)
        else $error("sync driven high");
    a_sync_one_cyc: assert property (!sync_oe_n |=> sync_oe_n)
        else $error("sync pulse too long");
    c_read: cover property (rd_stb);
    c_prof: cover property ($rose(prof_flag));
    c_irq: cover property ($rose(irq));
endmodule
bind smc_core smc_chk u_chk (.mclk(mclk), .rst(rst), .rd_stb(rd_stb), .ad_out(ad_out),
    .ad_oe_n(ad_oe_n), .limit_n(limit_n), .stop_n(stop_n), .sync_out(sync_out),
    .sync_oe_n(sync_oe_n), .mcmd(mcmd), .pwm_out(pwm_out), .phase(phase),
    .prof_flag(prof_flag), .init_flag(init_flag), .irq(irq));

// ---- verification/smc_core_tb.sv ----
`timescale 1ns/1ns
module smc_core_tb import smc_pkg::*;;
    logic       mclk, rst, ale, wr_stb, rd_stb, limit_n, stop_n, enc_a, enc_b;
    logic [7:0] host_ad, ad_out, mcmd;
    logic       ad_oe_n, sync_out, sync_oe_n, pwm_out, pwm_sign, prof_flag, init_flag, irq;
    logic [2:0] phase;
    wire  [7:0] ad_in   = ad_oe_n ? host_ad : ad_out;
    // sync wire has a pull-up; the device only pulls low
    wire        sync_in = sync_oe_n ? 1'b1 : sync_out;
    int         mismatches = 0;
    int         tests_run = 0;
    int         h, i, n;
    logic [7:0] ra[7] = '{SMC_A_TIMER, SMC_A_GAIN, SMC_A_ZERO, SMC_A_ACC, SMC_A_VMAX,
                          SMC_A_SEG, SMC_A_MCMD};
    logic [7:0] rv[7] = '{SMC_RST_TIMER, SMC_RST_GAIN, SMC_RST_ZERO, SMC_RST_ACC,
                          SMC_RST_VMAX, SMC_RST_SEG, 8'h00};
    logic [7:0]  pp[3] = '{8'h00, 8'h14, 8'h28};
    logic [2:0]  ph[3] = '{3'h1, 3'h2, 3'h4};
    smc_core u_dut (.mclk(mclk), .rst(rst), .ale(ale), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .enc_a(enc_a), .enc_b(enc_b),
        .limit_n(limit_n), .stop_n(stop_n), .sync_in(sync_in), .sync_out(sync_out),
        .sync_oe_n(sync_oe_n), .mcmd(mcmd), .pwm_out(pwm_out), .pwm_sign(pwm_sign),
        .phase(phase), .prof_flag(prof_flag), .init_flag(init_flag), .irq(irq));
    smc_enc_model u_enc (.mclk(mclk), .enc_a(enc_a), .enc_b(enc_b));
    always #50 mclk = ~mclk;
    task automatic print_verdict();
        if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        // look just after the edge, once outputs have settled
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk); ale <= 1'b1; host_ad <= a;
        @(posedge mclk); ale <= 1'b0; wr_stb <= 1'b1; host_ad <= d;
        @(posedge mclk); wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk); ale <= 1'b1; host_ad <= a;
        @(posedge mclk); ale <= 1'b0; rd_stb <= 1'b1; host_ad <= ~a;
        @(posedge mclk); rd_stb <= 1'b0;
        #1 chk(ad_in, e);
    endtask
    task automatic wr3(input logic [7:0] a, input logic [23:0] v);
        for (int j = 0; j < 3; j++) wr(a + j[7:0], v[j*8 +: 8]);
    endtask
    task automatic rd3(input logic [7:0] a, input logic [23:0] e);
        for (int j = 0; j < 3; j++) rd(a + j[7:0], e[j*8 +: 8]);
    endtask
    // counts high cycles of pwm_out (sel 0) or low cycles of sync_oe_n (sel 1)
    task automatic count(input logic sel, input int k, output int c);
        c = 0;
        repeat (k) begin
            @(posedge mclk);
            #1 if (sel ? (sync_oe_n === 1'b0) : (pwm_out === 1'b1)) c++;
        end
    endtask
    initial begin
        mclk = 0; rst = 1; ale = 0; wr_stb = 0; rd_stb = 0; host_ad = 8'h00;
        limit_n = 1; stop_n = 1;
        cyc(20); rst <= 1'b0;
        #1 chk(init_flag, 1);
        for (i = 0; i < 7; i++) rd(ra[i], rv[i]);
        rd(8'h20, 8'h00);
        wr(SMC_A_MCMD, 8'h55); rd(SMC_A_MCMD, 8'h00);
        wr(SMC_A_TIMER, 8'h00);
        // a new period is taken only when the running one expires
        cyc(1000);
        wr3(SMC_A_POS0, 24'hffffff); u_enc.step(1); rd3(SMC_A_POS0, 24'h000000);
        u_enc.step(0); rd3(SMC_A_POS0, 24'hffffff);
        wr3(SMC_A_POS0, 24'h0);
        repeat (4) u_enc.step(1);
        rd3(SMC_A_POS0, 24'd4);
        wr3(SMC_A_POS0, 24'h0); wr3(SMC_A_TGT0, 24'd100); wr(SMC_A_MODE, 8'h00);
        cyc(2); chk(init_flag, 0);
        cyc(60); chk(mcmd, 8'h64);
        cyc(300); count(0, 128, h); chk(h, 100); chk(pwm_sign, 0);
        wr3(SMC_A_TGT0, 24'hffff38); cyc(60); chk(mcmd, 8'h80);
        cyc(300); count(0, 128, h); chk(h, 127); chk(pwm_sign, 1);
        wr(SMC_A_MODE, 8'h01); cyc(2); chk(prof_flag, 0);
        wr(SMC_A_MODE, 8'h03); cyc(2); chk(prof_flag, 0);
        // short move: the profile needs four ticks, so the flag is seen high
        wr3(SMC_A_TGT0, 24'h000008); wr(SMC_A_MODE, 8'h02); cyc(2); chk(prof_flag, 1);
        for (n = 0; n < 5000 && prof_flag !== 1'b0; n++) @(posedge mclk);
        if (n == 5000) mismatches++;
        cyc(3); chk(irq, 0); rd(SMC_A_ISTS, 8'h01);
        wr(SMC_A_IEN, 8'h01); cyc(3); chk(irq, 1);
        wr(SMC_A_ICLR, 8'h01); cyc(3); chk(irq, 0); rd(SMC_A_ISTS, 8'h00);
        stop_n <= 1'b0; cyc(10); rd(SMC_A_ISTS, 8'h04); chk(mcmd, 8'h00);
        limit_n <= 1'b0; cyc(10); rd(SMC_A_ISTS, 8'h06); chk(phase, 3'h0);
        stop_n <= 1'b1; limit_n <= 1'b1; wr(SMC_A_ICLR, 8'h06);
        wr(SMC_A_MODE, 8'h0c);
        // commutator index sits 4 counts in from the encoder steps; advance moves it
        for (i = 0; i < 3; i++) begin
            wr(SMC_A_ADV, pp[i]); cyc(8); chk(phase, ph[i]);
        end
        wr(SMC_A_OVL, 8'h08); wr(SMC_A_ADV, 8'h10); cyc(8); chk(phase, 3'h3);
        count(1, 160, h); chk(h, 10);
        print_verdict();
    end
endmodule
